// [rtl/pis_pkg.sv]
// Purpose: Shared constants and types for the interrupt scheduler.
// Assumes: One 100 MHz clock, asynchronous active-low reset.
// Notes: Functional notes follow.
// Functional notes
// R1: Normal mode waits for current process end.
// R2: High-speed mode breaks current process at once.
// R3: Mode resets to normal; setup selects high-speed.
// R4: Normal mode completes four service kinds first.
// R5: High-speed mode suspends service, starts subroutine.
// R6: Two input modules, eight lines each.
// R7: Module lines map to interrupts 00-15.
// R8: Schedule unit is 10 ms or 1 ms.
// R9: Scheduled interrupt is number 99.
// R10: Schedule repeats independent of scan cycle.
// R11: No nesting; pending held until subroutine ends.
// R12: Lowest input number first, scheduled last.
// R13: Masked stays pending; clear and interval control.
// R14: Resume main program after interrupted point.
// R15: Software chooses mode for response needs.
// R16: Software guards shared multi-word data.
// R17: High-speed run of 10 ms raises error 8B. Code raises it only while units_present_in is set.
// R18: Record longest run time and its number.
// R19: Each of seventeen sources has pending latch.
package pis_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_1MS_CYC = CLK_HZ / 1000;
    localparam int unsigned TICK_100US_CYC = CLK_HZ / 10000;
    localparam int unsigned LONG_RUN_MS = 10;
    localparam int unsigned RUN_UNITS_PER_MS = 10;
    localparam logic [3:0] UNIT_DIV_LAST = 4'h9;
    localparam logic [3:0] BCD_DIGIT_LAST = 4'h9;
    localparam logic [3:0] BCD_TEN = 4'ha;
    localparam int unsigned MODULE_LINES = 8;
    localparam int unsigned NUM_SOURCES = 17;
    localparam logic [4:0] SCHED_INDEX = 5'h10;
    localparam logic [7:0] SCHED_NUMBER = 8'h99;
    localparam logic [7:0] ERR_CODE_LONG = 8'h8b;
    localparam logic [15:0] TIME_RESET = 16'h0000;
    localparam logic [7:0] NUMBER_RESET = 8'h00;
    typedef enum logic [1:0] {
        PIS_IDLE = 2'b00,
        PIS_WAIT = 2'b01,
        PIS_RUN = 2'b11
    } pis_state_t;
    function automatic logic [7:0] pis_number(input logic [4:0] idx);
        // Numbers are shown in decimal digits, so 10 to 15 carry into the upper digit.
        if (idx == SCHED_INDEX) begin
            pis_number = SCHED_NUMBER;
        end else if (idx[3:0] > BCD_DIGIT_LAST) begin
            pis_number = {4'h1, idx[3:0] - BCD_TEN};
        end else begin
            pis_number = {4'h0, idx[3:0]};
        end
    endfunction : pis_number
endpackage : pis_pkg

// [rtl/pis_tick_gen.sv]
// Purpose: Free-running tick divider for the scheduler and timers.
// Assumes: Count is at least one cycle.
// Notes: Runs without regard to the program scan.
`timescale 1ns/1ns
module pis_tick_gen #(
    parameter int unsigned COUNT = 100_000
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Restart and tick
    input wire logic restart_in,
    output logic tick_out
);
    logic [31:0] count;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= 32'h0;
            tick_out <= 1'b0;
        end else if (restart_in || count == COUNT - 1) begin
            count <= 32'h0;
            tick_out <= !restart_in;
        end else begin
            count <= count + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule : pis_tick_gen

// [rtl/pis_prio_pick.sv]
// Purpose: Fixed-priority pick among ready sources.
// Assumes: Index 0 highest, scheduled source last.
// Notes: Pure combinational.
`timescale 1ns/1ns
module pis_prio_pick #(
    parameter int unsigned N = 17
) (
    // Requests
    input wire logic [N-1:0] ready_in,
    // Choice
    output logic any_out,
    output logic [4:0] index_out
);
    always_comb begin
        any_out = 1'b0;
        index_out = 5'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (ready_in[i]) begin
                any_out = 1'b1;
                index_out = 5'(i); // R12
            end
        end
    end
endmodule : pis_prio_pick

// [rtl/pis_scheduler.sv]
// Purpose: Interrupt pending, priority, dispatch and subroutine timing.
// Assumes: Sequencer reports process busy/atomic and subroutine end.
// Notes: One subroutine at a time; the return point is held here.
`timescale 1ns/1ns
module pis_scheduler #(
    parameter int unsigned TICK_1MS = pis_pkg::TICK_1MS_CYC,
    parameter int unsigned TICK_100US = pis_pkg::TICK_100US_CYC,
    parameter int unsigned PC_WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Interrupt input module lines
    input wire logic [7:0] first_module_lines_in,
    input wire logic [7:0] second_module_lines_in,
    // Setup and control
    input wire logic high_speed_mode_in,
    input wire logic sched_unit_1ms_in,
    input wire logic [15:0] sched_interval_in,
    input wire logic sched_enable_in,
    input wire logic [16:0] mask_in,
    input wire logic [16:0] clear_in,
    input wire logic units_present_in,
    // Program sequencer
    input wire logic process_busy_in,
    input wire logic [PC_WIDTH-1:0] main_pc_in,
    input wire logic subroutine_done_in,
    // Dispatch outputs
    output logic suspend_out,
    output logic dispatch_out,
    output logic [7:0] subroutine_number_out,
    output logic return_valid_out,
    output logic [PC_WIDTH-1:0] return_pc_out,
    // Status outputs
    output logic [16:0] pending_out,
    output logic [15:0] max_isr_time_word_out,
    output logic [7:0] max_isr_number_word_out,
    output logic error_valid_out,
    output logic [7:0] error_code_out
);
    pis_pkg::pis_state_t state;
    logic [16:0] pending;
    logic [16:0] lines_prev;
    logic [16:0] rise;
    logic mode_high;
    logic sched_tick_1ms;
    logic sched_tick_unit;
    logic [3:0] unit_div;
    logic [15:0] interval_count;
    logic sched_fire;
    logic any_ready;
    logic [4:0] pick_index;
    logic [4:0] active_index;
    logic run_tick;
    logic [15:0] run_time;
    logic long_flag;

    assign rise = {1'b0, second_module_lines_in, first_module_lines_in} & ~lines_prev; // R6 R7

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lines_prev <= 17'h0;
        end else begin
            lines_prev <= {1'b0, second_module_lines_in, first_module_lines_in};
        end
    end

    // Mode is sampled only when idle so a running subroutine is never re-judged.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_high <= 1'b0; // R3
        end else if (state == pis_pkg::PIS_IDLE) begin
            mode_high <= high_speed_mode_in; // R3
        end
    end

    pis_tick_gen #(.COUNT(TICK_1MS)) u_sched_tick (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(1'b0),
        .tick_out(sched_tick_1ms)
    );

    // Ten-millisecond unit built from the one-millisecond tick.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unit_div <= 4'h0;
        end else if (sched_tick_1ms) begin
            unit_div <= (unit_div == pis_pkg::UNIT_DIV_LAST) ? 4'h0 : unit_div + 4'h1;
        end
    end
    assign sched_tick_unit = sched_tick_1ms && (sched_unit_1ms_in || unit_div == pis_pkg::UNIT_DIV_LAST); // R8

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            interval_count <= 16'h0;
            sched_fire <= 1'b0;
        end else begin
            sched_fire <= 1'b0;
            if (!sched_enable_in || sched_interval_in == 16'h0) begin
                interval_count <= 16'h0;
            end else if (sched_tick_unit) begin
                if (interval_count + 16'h1 >= sched_interval_in) begin
                    interval_count <= 16'h0;
                    sched_fire <= 1'b1; // R10
                end else begin
                    interval_count <= interval_count + 16'h1;
                end
            end
        end
    end

    // Set wins over clear and over dispatch so no event is lost.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pending <= 17'h0;
        end else begin
            logic [16:0] set_bits;
            logic [16:0] drop_bits;
            set_bits = rise | (17'(sched_fire) << pis_pkg::SCHED_INDEX); // R9 R19
            drop_bits = clear_in; // R13
            if (dispatch_out) begin
                drop_bits[active_index] = 1'b1; // R19
            end
            pending <= (pending & ~drop_bits) | set_bits; // R13 R19
        end
    end

    pis_prio_pick #(.N(pis_pkg::NUM_SOURCES)) u_pick (
        .ready_in(pending & ~mask_in), // R13
        .any_out(any_ready),
        .index_out(pick_index)
    );

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= pis_pkg::PIS_IDLE;
            active_index <= 5'h0;
            suspend_out <= 1'b0;
            dispatch_out <= 1'b0;
            subroutine_number_out <= 8'h0;
            return_valid_out <= 1'b0;
            return_pc_out <= '0;
        end else begin
            dispatch_out <= 1'b0;
            unique case (state)
                pis_pkg::PIS_IDLE: begin
                    return_valid_out <= 1'b0;
                    if (any_ready) begin
                        active_index <= pick_index; // R12
                        state <= pis_pkg::PIS_WAIT;
                    end
                end
                pis_pkg::PIS_WAIT: begin
                    if (mode_high || !process_busy_in) begin // R1 R2 R4 R5
                        suspend_out <= 1'b1; // R2 R5
                        dispatch_out <= 1'b1;
                        subroutine_number_out <= pis_pkg::pis_number(active_index); // R7 R9
                        return_pc_out <= main_pc_in; // R14
                        state <= pis_pkg::PIS_RUN;
                    end
                end
                pis_pkg::PIS_RUN: begin
                    if (subroutine_done_in) begin // R11
                        suspend_out <= 1'b0;
                        return_valid_out <= 1'b1; // R14
                        state <= pis_pkg::PIS_IDLE;
                    end
                end
                default: begin
                    state <= pis_pkg::PIS_IDLE;
                end
            endcase
        end
    end

    pis_tick_gen #(.COUNT(TICK_100US)) u_run_tick (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(dispatch_out),
        .tick_out(run_tick)
    );

    // Run time saturates rather than wraps so the maximum stays honest.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_time <= pis_pkg::TIME_RESET;
            max_isr_time_word_out <= pis_pkg::TIME_RESET;
            max_isr_number_word_out <= pis_pkg::NUMBER_RESET;
        end else if (dispatch_out) begin
            run_time <= pis_pkg::TIME_RESET;
        end else if (state == pis_pkg::PIS_RUN) begin
            if (run_tick && run_time != 16'hffff) begin
                run_time <= run_time + 16'h1;
            end
            if (subroutine_done_in && run_time > max_isr_time_word_out) begin
                max_isr_time_word_out <= run_time; // R18
                max_isr_number_word_out <= subroutine_number_out; // R18
            end
        end
    end

    assign long_flag = mode_high && units_present_in && state == pis_pkg::PIS_RUN
        && run_time >= 16'(pis_pkg::LONG_RUN_MS * pis_pkg::RUN_UNITS_PER_MS);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            error_valid_out <= 1'b0;
            error_code_out <= 8'h0;
        end else if (long_flag) begin
            error_valid_out <= 1'b1; // R17
            error_code_out <= pis_pkg::ERR_CODE_LONG; // R17
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pending_out <= 17'h0;
        end else begin
            pending_out <= pending;
        end
    end
endmodule : pis_scheduler

// [tb/pis_scheduler_props.sv]
// Purpose: Port checks for the scheduler.
// Assumes: One clock, active-low reset.
// Notes: Bound from the bench.
`timescale 1ns/1ns
module pis_scheduler_props (
    // Watched ports
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] first_module_lines_in,
    input wire logic high_speed_mode_in,
    input wire logic [16:0] mask_in,
    input wire logic process_busy_in,
    input wire logic subroutine_done_in,
    input wire logic suspend_out,
    input wire logic dispatch_out,
    input wire logic return_valid_out,
    input wire logic [16:0] pending_out,
    input wire logic error_valid_out,
    input wire logic [7:0] error_code_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    disp_pulse_a: assert property (dispatch_out |=> !dispatch_out)
        else $error("dispatch too long");
    disp_susp_a: assert property (dispatch_out |-> suspend_out)
        else $error("dispatch without suspend");
    no_nest_a: assert property (suspend_out && $past(suspend_out) |-> !dispatch_out)
        else $error("nested dispatch");
    normal_wait_a: assert property (dispatch_out && !high_speed_mode_in |-> !$past(process_busy_in))
        else $error("dispatch during busy process");
    resume_a: assert property (suspend_out && subroutine_done_in |=> !suspend_out && return_valid_out)
        else $error("no resume after done");
    ret_pulse_a: assert property (return_valid_out |=> !return_valid_out)
        else $error("return pulse too long");
    hs_answer_a: assert property ($rose(first_module_lines_in[0]) && high_speed_mode_in && !suspend_out
        && !mask_in[0] |-> ##[1:4] dispatch_out) else $error("slow dispatch");
    pend_set_a: assert property ($rose(first_module_lines_in[2]) |-> ##[1:2] pending_out[2])
        else $error("pending not set");
    err_sticky_a: assert property (error_valid_out |=> error_valid_out && error_code_out == 8'h8b)
        else $error("error flag or code wrong");
endmodule : pis_scheduler_props

// [tb/pis_seq_model.sv]
// Purpose: Program sequencer model.
// Assumes: One clock.
// Notes: Ends a subroutine after run_len_in cycles.
`timescale 1ns/1ns
module pis_seq_model (
    // Clock and control
    input wire logic sys_clk_in,
    input wire logic dispatch_in,
    input wire logic [15:0] run_len_in,
    // Subroutine end
    output logic done_out
);
    int cnt = 0;
    initial done_out = 1'b0;
    always @(posedge sys_clk_in) begin
        done_out <= 1'b0;
        if (dispatch_in) begin
            cnt <= 1;
        end else if (cnt != 0 && cnt >= int'(run_len_in)) begin
            done_out <= 1'b1;
            cnt <= 0;
        end else if (cnt != 0) begin
            cnt <= cnt + 1;
        end
    end
endmodule : pis_seq_model

// [tb/test_plc_interrupt_scheduler.sv]
// Purpose: Self-checking bench for the scheduler.
// Assumes: Ticks shortened to 10 and 1 cycles.
// Notes: Row loop first, then hand tests.
`timescale 1ns/1ns
module test_plc_interrupt_scheduler;
    typedef struct {int idx; logic hs; logic [7:0] num;} pis_row_t;
    logic sys_clk_in, rst_n_in, hs, unit_1ms, sched_en, units_present, busy, done;
    logic suspend, dispatch, ret_valid, err_valid;
    logic [7:0] lines_a, lines_b, num, number, max_num, err_code;
    logic [15:0] interval, main_pc, run_len, ret_pc, max_time;
    logic [16:0] mask, clr, pending;
    int bad_count = 0;
    int tests_run = 0;
    time t0;
    pis_row_t rows[6] = '{'{0, 1, 8'h00}, '{7, 1, 8'h07}, '{8, 1, 8'h08}, '{9, 1, 8'h09},
        '{15, 1, 8'h15}, '{5, 0, 8'h05}};
    pis_scheduler #(.TICK_1MS(10), .TICK_100US(1)) i_dut (.sys_clk_in, .rst_n_in,
        .first_module_lines_in(lines_a), .second_module_lines_in(lines_b), .high_speed_mode_in(hs),
        .sched_unit_1ms_in(unit_1ms), .sched_interval_in(interval), .sched_enable_in(sched_en),
        .mask_in(mask), .clear_in(clr), .units_present_in(units_present), .process_busy_in(busy),
        .main_pc_in(main_pc), .subroutine_done_in(done), .suspend_out(suspend), .dispatch_out(dispatch),
        .subroutine_number_out(number), .return_valid_out(ret_valid), .return_pc_out(ret_pc),
        .pending_out(pending), .max_isr_time_word_out(max_time), .max_isr_number_word_out(max_num),
        .error_valid_out(err_valid), .error_code_out(err_code));
    pis_seq_model i_seq (.sys_clk_in, .dispatch_in(dispatch), .run_len_in(run_len), .done_out(done));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : step
    task automatic fire(input int idx);
        {lines_b, lines_a} = 16'h0001 << idx;
        step(2);
        {lines_b, lines_a} = 16'h0000;
    endtask : fire
    task automatic wait_disp(output logic [7:0] got);
        int n = 0;
        while (dispatch !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
        got = (dispatch === 1'b1) ? number : 8'hee;
        step(1);
    endtask : wait_disp
    task automatic wait_idle();
        int n = 0;
        while (suspend !== 1'b0 && n < 400) begin
            step(1);
            n++;
        end
        chk("suspend", 16'h0000, {15'h0000, suspend});
    endtask : wait_idle
    task automatic sched_gap(input logic unit, input logic [15:0] exp_ns);
        unit_1ms = unit;
        wait_disp(num);
        wait_disp(num);
        t0 = $time;
        wait_disp(num);
        chk("sched number", 16'h0099, {8'h00, num});
        chk("sched period", exp_ns, 16'($time - t0));
        $display("schedule unit %b done", unit);
    endtask : sched_gap
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // The whole run needs well under 5000 cycles, so this only cuts a hang.
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    initial begin
        rst_n_in = 1'b0;
        {hs, unit_1ms, sched_en, units_present, busy} = 5'h08;
        {lines_a, lines_b, mask, clr} = '0;
        {interval, main_pc, run_len} = {16'h0002, 16'h0000, 16'h0004};
        step(6);
        rst_n_in = 1'b1;
        chk("reset state", 16'h0000, pending[15:0] | {15'h0000, suspend});
        foreach (rows[i]) begin
            hs = rows[i].hs;
            main_pc = 16'h0100 + 16'(rows[i].idx);
            step(2);
            fire(rows[i].idx);
            wait_disp(num);
            chk("number", {8'h00, rows[i].num}, {8'h00, num});
            chk("return pc", main_pc, ret_pc);
            wait_idle();
            $display("row %0d done", i);
        end
        busy = 1'b1;
        fire(4);
        step(20);
        chk("busy hold", 16'h0010, pending[15:0] | {15'h0000, suspend});
        busy = 1'b0;
        wait_disp(num);
        chk("normal number", 16'h0004, {8'h00, num});
        wait_idle();
        $display("normal wait done");
        hs = 1'b1;
        run_len = 16'h001e;
        step(2);
        fire(6);
        wait_disp(num);
        {lines_b, lines_a} = 16'h0006;
        step(3);
        chk("pending in run", 16'h0006, pending[15:0]);
        {lines_b, lines_a} = 16'h0000;
        wait_idle();
        wait_disp(num);
        chk("first pick", 16'h0001, {8'h00, num});
        wait_idle();
        wait_disp(num);
        chk("second pick", 16'h0002, {8'h00, num});
        wait_idle();
        $display("priority done");
        mask = 17'h00008;
        fire(3);
        step(10);
        chk("masked", 16'h0008, pending[15:0] | {15'h0000, suspend});
        clr = 17'h00008;
        step(2);
        {clr, mask} = '0;
        step(10);
        chk("cleared", 16'h0000, pending[15:0] | {15'h0000, suspend});
        $display("mask and clear done");
        run_len = 16'h0002;
        sched_en = 1'b1;
        sched_gap(1'b1, 16'h00c8);
        sched_gap(1'b0, 16'h07d0);
        sched_en = 1'b0;
        clr = 17'h10000;
        step(2);
        clr = '0;
        wait_idle();
        units_present = 1'b1;
        run_len = 16'h0082;
        fire(12);
        wait_disp(num);
        wait_idle();
        step(2);
        chk("long run error", 16'h018b, {7'h00, err_valid, err_code});
        chk("longest number", 16'h0012, {8'h00, max_num});
        // The run lasts about 130 one-unit ticks, less the dispatch and done handshake.
        chk("longest time", 16'h0001, {15'h0000, max_time >= 16'h0080 && max_time <= 16'h0083});
        $display("long run done");
        close_out();
    end
endmodule : test_plc_interrupt_scheduler
bind pis_scheduler pis_scheduler_props i_props (.sys_clk_in, .rst_n_in, .first_module_lines_in,
    .high_speed_mode_in, .mask_in, .process_busy_in, .subroutine_done_in, .suspend_out, .dispatch_out,
    .return_valid_out, .pending_out, .error_valid_out, .error_code_out);
